/* File: common/ebm_regs.vh */
`ifndef EBM_REGS_VH
`define EBM_REGS_VH

// register indices on the plain register port
`define EBM_ADDR_W 4
`define EBM_REG_PB_PER 4'h0
`define EBM_REG_CLKOSEL 4'h1
`define EBM_REG_BUS_CTRL 4'h2
`define EBM_REG_PB_DDR 4'h3
`define EBM_REG_PB_DOUT 4'h4
`define EBM_REG_PB_PUR 4'h5
`define EBM_REG_PB_PIN 4'h6
`define EBM_REG_PF_PER 4'h7
`define EBM_REG_PF_DDR 4'h8
`define EBM_REG_PF_DOUT 4'h9
`define EBM_REG_PF_PUR 4'ha
`define EBM_REG_PF_PIN 4'hb

// field positions
`define EBM_BUS_DRV_BIT 0
`define EBM_PB_LO 4
`define EBM_PB_HI 7
`define EBM_PF_LO 9
`define EBM_PF_HI 15

// reset values
`define EBM_PB_PER_RST 16'h0000
`define EBM_PF_PER_RST 16'hfe00
`define EBM_CLKOSEL_RST 16'h0000
`define EBM_BUS_CTRL_RST 16'h0000
`define EBM_PUR_RST 16'hffff
`define EBM_ZERO16 16'h0000

`endif

/* File: verilog/ebm_pin_cell.v */
`timescale 1ns/10ps
`default_nettype none

// one shared pin: gpio or peripheral, purely combinational
module ebm_pin_cell (
    input wire per_en,
    input wire gpio_dir,
    input wire gpio_out,
    input wire per_out,
    input wire per_oe,
    output wire pin_o,
    output wire pin_oe
);
    // peripheral enable takes the pin away from gpio
    assign pin_o = per_en ? per_out : gpio_out;
    assign pin_oe = per_en ? per_oe : gpio_dir;
endmodule

`default_nettype wire

/* File: verilog/ebm_pin_mux.v */
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "ebm_regs.vh"

// What this block does
// - clock monitor: four clocks onto pins 4-7
// - port b 4-7 are gpio after reset
// - peripheral enable bit takes pin from gpio
// - clock select picks address or clock on pins 5-7, clock or nothing on pin 4
// - address mode: high address on pins 5-7
// - drive hold keeps data lines driven idle while ext_data_low_bits_write is set
// - data lines tristated in reset, bus default
// - port f pins 9-15 each input or output
// - pullup enable bit n serves port f pin n
// - port b pullup enable bit turns pullup on
module ebm_pin_mux #(
    parameter ADDR_HI_W = 3
) (
    input wire clock,
    input wire reset,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [15:0] reg_rdata,
    input wire prescaled_clock,
    input wire system_clock_out,
    input wire system_clock_alt,
    input wire crystal_clock,
    input wire [ADDR_HI_W-1:0] ext_address_high_bits,
    input wire bus_access,
    input wire [6:0] ext_data_low_bits_out,
    input wire ext_data_low_bits_write,
    output wire [6:0] ext_data_low_bits_in,
    input wire [3:0] port_b_pin_i,
    output reg [3:0] port_b_pin_o,
    output reg [3:0] port_b_pin_oe,
    output reg [3:0] port_b_pullup,
    input wire [6:0] port_f_pin_i,
    output reg [6:0] port_f_pin_o,
    output reg [6:0] port_f_pin_oe,
    output reg [6:0] port_f_pullup
);
    // software registers
    reg [15:0] pb_per_q;
    reg [15:0] clkosel_q;
    reg [15:0] bus_ctrl_q;
    reg [15:0] pb_ddr_q;
    reg [15:0] pb_dout_q;
    reg [15:0] pb_pur_q;
    reg [15:0] pf_per_q;
    reg [15:0] pf_ddr_q;
    reg [15:0] pf_dout_q;
    reg [15:0] pf_pur_q;
    // pin input synchronisers
    reg [3:0] pb_s1_q;
    reg [3:0] pb_s2_q;
    reg [6:0] pf_s1_q;
    reg [6:0] pf_s2_q;
    // combinational pin drive
    wire [3:0] pb_o;
    wire [3:0] pb_oe;
    wire [6:0] pf_o;
    wire [6:0] pf_oe;
    reg [3:0] pb_per_out;
    reg [3:0] pb_per_oe;
    wire bus_drv;
    wire data_oe;
    reg [15:0] rd_d;

    // register writes
    always @(posedge clock) begin
        if (reset) begin
            pb_per_q <= `EBM_PB_PER_RST;
            clkosel_q <= `EBM_CLKOSEL_RST;
            bus_ctrl_q <= `EBM_BUS_CTRL_RST; // bus floats when idle
            pb_ddr_q <= `EBM_ZERO16;
            pb_dout_q <= `EBM_ZERO16;
            pb_pur_q <= `EBM_PUR_RST;
            pf_per_q <= `EBM_PF_PER_RST;
            pf_ddr_q <= `EBM_ZERO16;
            pf_dout_q <= `EBM_ZERO16;
            pf_pur_q <= `EBM_PUR_RST;
        end else if (reg_write) begin
            case (reg_addr)
                `EBM_REG_PB_PER: pb_per_q <= reg_wdata;
                `EBM_REG_CLKOSEL: clkosel_q <= reg_wdata;
                `EBM_REG_BUS_CTRL: bus_ctrl_q <= reg_wdata;
                `EBM_REG_PB_DDR: pb_ddr_q <= reg_wdata;
                `EBM_REG_PB_DOUT: pb_dout_q <= reg_wdata;
                `EBM_REG_PB_PUR: pb_pur_q <= reg_wdata;
                `EBM_REG_PF_PER: pf_per_q <= reg_wdata;
                `EBM_REG_PF_DDR: pf_ddr_q <= reg_wdata;
                `EBM_REG_PF_DOUT: pf_dout_q <= reg_wdata;
                `EBM_REG_PF_PUR: pf_pur_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // two-stage synchronisers on pin inputs
    always @(posedge clock) begin
        if (reset) begin
            pb_s1_q <= 4'h0;
            pb_s2_q <= 4'h0;
            pf_s1_q <= 7'h00;
            pf_s2_q <= 7'h00;
        end else begin
            pb_s1_q <= port_b_pin_i;
            pb_s2_q <= pb_s1_q;
            pf_s1_q <= port_f_pin_i;
            pf_s2_q <= pf_s1_q;
        end
    end

    // peripheral source per port b pin: clock monitor, or address on pins 5-7 only
    always @* begin
        pb_per_out = 4'h0;
        pb_per_oe = 4'h0;
        if (clkosel_q[`EBM_PB_LO]) begin
            pb_per_out[0] = prescaled_clock;
            pb_per_oe[0] = 1'b1;
        end
        if (clkosel_q[`EBM_PB_LO+1]) begin
            pb_per_out[1] = system_clock_out;
            pb_per_oe[1] = 1'b1;
        end else begin
            pb_per_out[1] = ext_address_high_bits[0];
            pb_per_oe[1] = data_oe;
        end
        if (clkosel_q[`EBM_PB_LO+2]) begin
            pb_per_out[2] = system_clock_alt;
            pb_per_oe[2] = 1'b1;
        end else begin
            pb_per_out[2] = ext_address_high_bits[1];
            pb_per_oe[2] = data_oe;
        end
        if (clkosel_q[`EBM_PB_HI]) begin
            pb_per_out[3] = crystal_clock;
            pb_per_oe[3] = 1'b1;
        end else begin
            pb_per_out[3] = ext_address_high_bits[ADDR_HI_W-1];
            pb_per_oe[3] = data_oe;
        end
    end

    // address and data lines float when idle unless drive hold set
    assign bus_drv = bus_ctrl_q[`EBM_BUS_DRV_BIT];
    assign data_oe = bus_access | bus_drv;

    // one cell per shared pin, no register in the cell
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pb
            ebm_pin_cell u_cell (
                .per_en(pb_per_q[`EBM_PB_LO+gi]),
                .gpio_dir(pb_ddr_q[`EBM_PB_LO+gi]),
                .gpio_out(pb_dout_q[`EBM_PB_LO+gi]),
                .per_out(pb_per_out[gi]),
                .per_oe(pb_per_oe[gi]),
                .pin_o(pb_o[gi]),
                .pin_oe(pb_oe[gi])
            );
        end
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_pf
            ebm_pin_cell u_cell (
                .per_en(pf_per_q[`EBM_PF_LO+gi]),
                .gpio_dir(pf_ddr_q[`EBM_PF_LO+gi]),
                .gpio_out(pf_dout_q[`EBM_PF_LO+gi]),
                .per_out(ext_data_low_bits_out[gi]),
                .per_oe(ext_data_low_bits_write & data_oe),
                .pin_o(pf_o[gi]),
                .pin_oe(pf_oe[gi])
            );
        end
    endgenerate

    // pin outputs registered; enables forced off during reset
    always @(posedge clock) begin
        if (reset) begin
            port_b_pin_o <= 4'h0;
            port_b_pin_oe <= 4'h0;
            port_f_pin_o <= 7'h00;
            port_f_pin_oe <= 7'h00;
            port_b_pullup <= 4'hf;
            port_f_pullup <= 7'h7f;
        end else begin
            port_b_pin_o <= pb_o;
            port_b_pin_oe <= pb_oe;
            port_f_pin_o <= pf_o;
            port_f_pin_oe <= pf_oe;
            port_b_pullup <= pb_pur_q[`EBM_PB_HI:`EBM_PB_LO];
            port_f_pullup <= pf_pur_q[`EBM_PF_HI:`EBM_PF_LO];
        end
    end

    // data bus input view of the low data pins
    assign ext_data_low_bits_in = pf_s2_q;

    // read mux
    always @* begin
        case (reg_addr)
            `EBM_REG_PB_PER: rd_d = pb_per_q;
            `EBM_REG_CLKOSEL: rd_d = clkosel_q;
            `EBM_REG_BUS_CTRL: rd_d = bus_ctrl_q;
            `EBM_REG_PB_DDR: rd_d = pb_ddr_q;
            `EBM_REG_PB_DOUT: rd_d = pb_dout_q;
            `EBM_REG_PB_PUR: rd_d = pb_pur_q;
            `EBM_REG_PB_PIN: rd_d = {8'h00, pb_s2_q, 4'h0};
            `EBM_REG_PF_PER: rd_d = pf_per_q;
            `EBM_REG_PF_DDR: rd_d = pf_ddr_q;
            `EBM_REG_PF_DOUT: rd_d = pf_dout_q;
            `EBM_REG_PF_PUR: rd_d = pf_pur_q;
            `EBM_REG_PF_PIN: rd_d = {pf_s2_q, 9'h000};
            default: rd_d = 16'h0000;
        endcase
    end

    // read data valid the cycle after the strobe only
    always @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

`default_nettype wire

/* File: dv/ebm_pin_mux_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// pin drive checked against shadowed selection state
module ebm_pin_mux_checker #(
    parameter ADDR_HI_W = 3
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic prescaled_clock,
    input wire logic system_clock_out,
    input wire logic system_clock_alt,
    input wire logic crystal_clock,
    input wire logic [ADDR_HI_W-1:0] ext_address_high_bits,
    input wire logic bus_access,
    input wire logic [6:0] ext_data_low_bits_out,
    input wire logic ext_data_low_bits_write,
    input wire logic [6:0] ext_data_low_bits_in,
    input wire logic [3:0] port_b_pin_o,
    input wire logic [3:0] port_b_pin_oe,
    input wire logic [3:0] port_b_pullup,
    input wire logic [6:0] port_f_pin_i,
    input wire logic [6:0] port_f_pin_oe,
    input wire logic [6:0] port_f_pin_o,
    input wire logic [6:0] port_f_pullup
);
    logic [3:0] per_q; // port b peripheral enable
    logic [3:0] sel_q; // clock output select
    logic [6:0] pfp_q; // port f peripheral enable
    logic drv_q; // bus drive hold
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // shadow of the selection registers
    always @(posedge clock) begin
        if (reset) begin
            {per_q, sel_q, drv_q, pfp_q} <= {9'h000, 7'h7f};
        end else if (reg_write) begin
            case (reg_addr)
                4'h0: per_q <= reg_wdata[7:4];
                4'h1: sel_q <= reg_wdata[7:4];
                4'h2: drv_q <= reg_wdata[0];
                4'h7: pfp_q <= reg_wdata[15:9];
                default: ;
            endcase
        end
    end
    AST_RST_OE: assert property (
        $fell(reset) |-> (port_b_pin_oe | port_f_pin_oe) == 7'h00)
        else $error("pins driven after reset");
    AST_RST_PULL: assert property (
        $fell(reset) |-> &{port_b_pullup, port_f_pullup})
        else $error("pullup off after reset");
    AST_CLK_MON: assert property (
        (per_q & sel_q) == 4'hf |=> port_b_pin_oe == 4'hf && port_b_pin_o
        == $past({crystal_clock, system_clock_alt, system_clock_out,
        prescaled_clock})) else $error("clock monitor wrong");
    AST_ADDR: assert property (
        per_q == 4'hf && sel_q == 4'h0 && (bus_access || drv_q) |=>
        port_b_pin_oe[3:1] == 3'h7 &&
        port_b_pin_o[3:1] == $past(ext_address_high_bits))
        else $error("address lines wrong");
    AST_ADDR_IDLE: assert property (
        per_q == 4'hf && sel_q == 4'h0 && !bus_access && !drv_q |=>
        port_b_pin_oe[3:1] == 3'h0) else $error("address driven idle");
    AST_DATA_IDLE: assert property (
        pfp_q == 7'h7f && !bus_access && !drv_q |=> port_f_pin_oe == 7'h00)
        else $error("data driven idle");
    AST_DATA_DRV: assert property (
        pfp_q == 7'h7f && ext_data_low_bits_write && (bus_access || drv_q)
        |=> port_f_pin_oe == 7'h7f &&
        port_f_pin_o == $past(ext_data_low_bits_out))
        else $error("data not driven");
    AST_DATA_IN: assert property (
        !$past(reset) && !$past(reset, 2) |->
        ext_data_low_bits_in == $past(port_f_pin_i, 2))
        else $error("data input path wrong");
endmodule
bind ebm_pin_mux ebm_pin_mux_checker #(.ADDR_HI_W(ADDR_HI_W)) u_chk (.*);
`default_nettype wire

/* File: dv/ebm_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// external memory on the low data lines
module ebm_mem_model (
    input wire logic [6:0] pin_oe,
    input wire logic [6:0] pin_o,
    input wire logic [6:0] pull,
    input wire logic drive,
    input wire logic [6:0] data,
    output logic [6:0] pin_i
);
    // device drive wins, then memory, then pullup or inverse of last
    assign pin_i = (pin_oe & pin_o) |
        (~pin_oe & (drive ? data : (pull | ~pin_o)));
endmodule
`default_nettype wire

/* File: dv/tb_ebm_pin_mux.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        n_mismatch++; \
        $display("mismatch %0t %h %h", $time, a, b); \
    end \
end
// bench for the shared pin mux
module tb_ebm_pin_mux;
    logic clock = 0, reset = 1, wr = 0, rd = 0, bus = 0, dwr = 0, mrd = 0;
    logic [3:0] a = 4'h0, mon = 4'h0, pb_o, pb_oe, pb_pu, pb_i;
    logic [15:0] wd = 16'h0000, rdata;
    logic [2:0] adr = 3'h0;
    logic [6:0] dout = 7'h00, mdat = 7'h00, din, pf_i, pf_o, pf_oe, pf_pu;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    ebm_pin_mux dut (.clock(clock), .reset(reset), .reg_addr(a),
        .reg_wdata(wd), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
        .prescaled_clock(mon[0]), .system_clock_out(mon[1]),
        .system_clock_alt(mon[2]), .crystal_clock(mon[3]),
        .ext_address_high_bits(adr), .bus_access(bus),
        .ext_data_low_bits_out(dout), .ext_data_low_bits_write(dwr),
        .ext_data_low_bits_in(din), .port_b_pin_i(pb_i),
        .port_b_pin_o(pb_o), .port_b_pin_oe(pb_oe), .port_b_pullup(pb_pu),
        .port_f_pin_i(pf_i), .port_f_pin_o(pf_o), .port_f_pin_oe(pf_oe),
        .port_f_pullup(pf_pu));
    ebm_mem_model mem (.pin_oe(pf_oe), .pin_o(pf_o), .pull(pf_pu),
        .drive(mrd), .data(mdat), .pin_i(pf_i));
    assign pb_i = (pb_oe & pb_o) | (~pb_oe & (pb_pu | ~pb_o));
    initial forever #20 clock = ~clock;
    task automatic wreg(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        a <= ad;
        wd <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] ad, input logic [15:0] e);
        @(posedge clock);
        rd <= 1'b1;
        a <= ad;
        @(posedge clock);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    // lets the register and the output flop both land
    task automatic hold;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic test_done;
        $display("checked %0d mismatch %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            test_done;
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        #1 `CHK(pf_oe, 7'h00)
        `CHK(pb_oe, 4'h0)
        rreg(4'h0, 16'h0000);
        rreg(4'h7, 16'hfe00);
        rreg(4'ha, 16'hffff);
        rreg(4'hf, 16'h0000);
        // idle bus, drive hold clear: data lines float
        @(posedge clock);
        dwr <= 1'b1;
        dout <= 7'h2a;
        hold;
        `CHK(pf_oe, 7'h00)
        @(posedge clock);
        bus <= 1'b1;
        hold;
        `CHK(pf_o & pf_oe, 7'h2a)
        // memory answers a read
        @(posedge clock);
        dwr <= 1'b0;
        mrd <= 1'b1;
        mdat <= 7'h55;
        hold;
        hold;
        `CHK(din, 7'h55)
        @(posedge clock);
        mrd <= 1'b0;
        bus <= 1'b0;
        wreg(4'h2, 16'h0001);
        dwr <= 1'b1;
        hold;
        `CHK(pf_oe, 7'h7f)
        // port b pins as gpio outputs while still unclaimed
        wreg(4'h3, 16'h00f0);
        wreg(4'h4, 16'h0050);
        hold;
        `CHK({pb_oe, pb_o}, 8'hf5)
        rreg(4'h6, 16'h0050);
        // upper port b pins as high address lines
        @(posedge clock);
        adr <= 3'h5;
        wreg(4'h0, 16'h00f0);
        hold;
        `CHK({pb_oe[3:1], pb_o[3:1]}, 6'h3d)
        // drive hold off again: idle address lines float
        wreg(4'h2, 16'h0000);
        hold;
        `CHK(pb_oe[3:1], 3'h0)
        wreg(4'h2, 16'h0001);
        // clock monitor on all four pins
        @(posedge clock);
        mon <= 4'h5;
        wreg(4'h1, 16'h00f0);
        hold;
        `CHK(pb_o, 4'h5)
        @(posedge clock);
        mon <= 4'ha;
        hold;
        `CHK(pb_o, 4'ha)
        // port f released to gpio, alternate pins outputs
        wreg(4'h7, 16'h0000);
        wreg(4'h8, 16'haa00);
        hold;
        `CHK(pf_oe, 7'h55)
        rreg(4'hb, 16'h5400);
        wreg(4'ha, 16'hfdff);
        hold;
        `CHK(pf_pu, 7'h7e)
        wreg(4'h5, 16'hffef);
        hold;
        `CHK(pb_pu, 4'he)
        // reset again mid-run: defaults come back
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        #1 `CHK({pb_oe, pf_oe}, 11'h000)
        rreg(4'h0, 16'h0000);
        rreg(4'h7, 16'hfe00);
        test_done;
    end
endmodule
`default_nettype wire
